// [rtl/sfp_pkg.sv]
// Servo fault protection: shared constants, register map and carrier types.
// Assumes a 200 MHz controller clock and a 32-bit APB register bus.
`default_nettype none
package sfp_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_PERIOD_NS = 1000000; // One millisecond time base
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TEST_HOLD_S = 3; // Test button hold time
  localparam logic [15:0] TEST_HOLD_MS = 16'(TEST_HOLD_S * 1000);
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SOFT_LIMIT = 8'h04;
  localparam logic [7:0] OFS_HARD_LIMIT = 8'h08;
  localparam logic [7:0] OFS_OC_TIME = 8'h0C;
  localparam logic [7:0] OFS_POS_ERROR = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h1C;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_RESTART_BIT = 4; // Write-one pulse, reads zero
  localparam logic [3:0] CTRL_RESET = 4'h1; // 4x encoder, 60 C, fault on soft
  localparam logic [15:0] SOFT_LIMIT_RESET = 16'h000A;
  localparam logic [15:0] HARD_LIMIT_RESET = 16'h0BB8;
  localparam logic [15:0] OC_TIME_RESET = 16'h0BB8; // Milliseconds
  localparam logic [7:0] TEMP_60 = 8'h3C;
  localparam logic [7:0] TEMP_80 = 8'h50;
  localparam logic [7:0] TEMP_100 = 8'h64;
  // Status message characters
  localparam logic [7:0] MSG_OK = 8'h4B; // K
  localparam logic [7:0] MSG_HARD = 8'h48; // H
  localparam logic [7:0] MSG_OVERLOAD = 8'h4F; // O
  localparam logic [7:0] MSG_THERMAL = 8'h54; // T
  localparam logic [7:0] MSG_STOP = 8'h53; // S
  localparam int NUM_EVENTS = 5;
  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] temp_sel; // 0: 60 C, 1: 80 C, 2 and 3: 100 C
    logic soft_nofault; // Suppress fault on soft-limit overrun
    logic enc4x; // 1: count every edge, 0: A edges only
  } sfp_ctrl_t;
  typedef struct packed {
    logic estop;
    logic thermal;
    logic overload;
    logic hard;
  } sfp_trip_t;
endpackage : sfp_pkg
`default_nettype wire

// [rtl/sfp_quad_decoder.sv]
// Quadrature decoder: turns two synchronised encoder channels into count pulses.
// Assumes channel A and B arrive already synchronised to clk.
`timescale 1ns/10ps
`default_nettype none
module sfp_quad_decoder (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc4x,
  output logic step,
  output logic dir_up
);
  logic a_q;
  logic b_q;
  wire edge_a = enc_a ^ a_q;
  wire edge_b = enc_b ^ b_q;
  // Direction from phase relation: A leading B counts up
  wire up_a = enc_a ^ enc_b;
  wire up_b = ~(enc_a ^ enc_b);
  wire next_step = edge_a | (enc4x & edge_b);
  wire next_dir = edge_a ? up_a : up_b;

  // ---------------------------------------------------------------
  // Edge detect and direction
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      step <= 1'b0;
      dir_up <= 1'b0;
    end else if (ce) begin
      a_q <= enc_a;
      b_q <= enc_b;
      step <= next_step;
      dir_up <= next_dir;
    end
  end
endmodule // sfp_quad_decoder
`default_nettype wire

// [rtl/sfp_top.sv]
// Servo fault protection supervisor with APB register access.
// Assumes cmd_pos comes from step logic on clk; pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Index or other extra encoder channels are not used at all.
// - Any independent trip brakes the motor and latches drive disable.
// - Latched trip clears only on restart or reset; emergency stop also clears on a test button hold.
// - Every independent trip asserts the fault output.
// - Position error magnitude above hard limit trips and latches.
// - Position error equals commanded minus actual position, zero at rest.
// - Current limiting continuously longer than overcurrent time trips and latches.
// - Heatsink at selected 60, 80 or 100 degree threshold disables drive.
// - Low emergency-stop input trips, brakes, disables and asserts fault.
// - Soft-limit overrun lights indicator A and faults unless suppressed; no brake.
// - High current limits PWM and lights indicator B without fault.
// - Each trip posts a status message and lights its cause indicator.
// - After emergency stop, restart or test button held over 3 s resumes.
// - Emergency stop acts at once in every state.
module sfp_top #(
  parameter int TICK_CYCLES = sfp_pkg::TICK_CYCLES,
  parameter int POS_W = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic estop_n,
  input wire logic test_button_n,
  input wire logic current_high,
  // Same-clock inputs
  input wire logic [POS_W-1:0] cmd_pos,
  input wire logic [7:0] heatsink_temp,
  // Outputs
  output logic brake,
  output logic drive_enable,
  output logic pwm_limit,
  output logic fault,
  output logic error_indicator_a,
  output logic current_indicator_b,
  output logic irq
);
  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [POS_W-1:0] mag(input logic [POS_W-1:0] v);
    mag = v[POS_W-1] ? POS_W'(-v) : v;
  endfunction
  function automatic logic [7:0] temp_limit(input logic [1:0] sel);
    case (sel)
      2'h0: temp_limit = sfp_pkg::TEMP_60;
      2'h1: temp_limit = sfp_pkg::TEMP_80;
      default: temp_limit = sfp_pkg::TEMP_100;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0] sync1;
  logic [4:0] sync2;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 5'h0C; // Stop and test idle high
      sync2 <= 5'h0C;
    end else if (ce) begin
      sync1 <= {current_high, test_button_n, estop_n, enc_b, enc_a};
      sync2 <= sync1;
    end
  end
  wire s_enc_a = sync2[0];
  wire s_enc_b = sync2[1];
  wire s_estop = ~sync2[2];
  wire s_test = ~sync2[3];
  wire s_cur = sync2[4];

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  sfp_pkg::sfp_ctrl_t ctrl;
  sfp_pkg::sfp_trip_t trip;
  logic [15:0] soft_limit;
  logic [15:0] hard_limit;
  logic [15:0] oc_time;
  logic [POS_W-1:0] actual_pos;
  logic [POS_W-1:0] pos_err;
  logic [31:0] tick_cnt;
  logic [15:0] oc_ms;
  logic [15:0] test_ms;
  logic [7:0] msg;
  logic [sfp_pkg::NUM_EVENTS-1:0] irq_st;
  logic [sfp_pkg::NUM_EVENTS-1:0] irq_en;
  logic soft_q;
  logic enc_step;
  logic enc_up;

  // Encoder front end; no index input exists, so extra channels cannot disturb counting
  sfp_quad_decoder u_quad (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .enc_a(s_enc_a),
    .enc_b(s_enc_b),
    .enc4x(ctrl.enc4x),
    .step(enc_step),
    .dir_up(enc_up)
  );

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire setup = psel & ~penable;
  wire wr_ok = psel & penable & pready & pwrite & ~pslverr;
  wire hit_ctrl = paddr == sfp_pkg::OFS_CTRL;
  wire hit_soft = paddr == sfp_pkg::OFS_SOFT_LIMIT;
  wire hit_hard = paddr == sfp_pkg::OFS_HARD_LIMIT;
  wire hit_oc = paddr == sfp_pkg::OFS_OC_TIME;
  wire hit_err = paddr == sfp_pkg::OFS_POS_ERROR;
  wire hit_stat = paddr == sfp_pkg::OFS_STATUS;
  wire hit_ist = paddr == sfp_pkg::OFS_IRQ_STATUS;
  wire hit_iclr = paddr == sfp_pkg::OFS_IRQ_CLEAR;
  wire hit_ien = paddr == sfp_pkg::OFS_IRQ_ENABLE;
  wire mapped = hit_ctrl | hit_soft | hit_hard | hit_oc | hit_err | hit_stat | hit_ist | hit_iclr | hit_ien;
  wire restart = wr_ok & hit_ctrl & pwdata[sfp_pkg::CTRL_RESTART_BIT];
  wire [sfp_pkg::NUM_EVENTS-1:0] irq_clr = (wr_ok & hit_iclr) ? pwdata[sfp_pkg::NUM_EVENTS-1:0] : '0;
  // Status word: message char, live conditions, latched causes
  wire [31:0] status_word = {16'h0000, msg, s_cur, soft_q, drive_enable, fault,
                             trip.estop, trip.thermal, trip.overload, trip.hard};
  wire [31:0] rd_mux =
      hit_ctrl ? {28'h0000000, ctrl} :
      hit_soft ? {16'h0000, soft_limit} :
      hit_hard ? {16'h0000, hard_limit} :
      hit_oc ? {16'h0000, oc_time} :
      hit_err ? 32'(signed'(pos_err)) :
      hit_stat ? status_word :
      hit_ist ? {27'h0000000, irq_st} :
      hit_ien ? {27'h0000000, irq_en} : 32'h00000000;

  // APB answer: one wait-free access cycle after setup, data registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (ce) begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup) prdata <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  // Writable configuration
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= sfp_pkg::CTRL_RESET;
      soft_limit <= sfp_pkg::SOFT_LIMIT_RESET;
      hard_limit <= sfp_pkg::HARD_LIMIT_RESET;
      oc_time <= sfp_pkg::OC_TIME_RESET;
      irq_en <= '0;
    end else if (ce && wr_ok) begin
      if (hit_ctrl) ctrl <= pwdata[3:0];
      if (hit_soft) soft_limit <= pwdata[15:0];
      if (hit_hard) hard_limit <= pwdata[15:0];
      if (hit_oc) oc_time <= pwdata[15:0];
      if (hit_ien) irq_en <= pwdata[sfp_pkg::NUM_EVENTS-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Position tracking
  // ---------------------------------------------------------------
  wire [POS_W-1:0] next_actual = enc_step ? (enc_up ? actual_pos + POS_W'(1) : actual_pos - POS_W'(1)) : actual_pos;
  wire [POS_W-1:0] err_mag = mag(pos_err);
  wire hard_over = err_mag > POS_W'(hard_limit);
  wire soft_over = err_mag > POS_W'(soft_limit);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      actual_pos <= '0;
      pos_err <= '0;
    end else if (ce) begin
      actual_pos <= next_actual;
      pos_err <= cmd_pos - actual_pos;
    end
  end

  // ---------------------------------------------------------------
  // Millisecond time base and timers
  // ---------------------------------------------------------------
  wire tick = tick_cnt == 32'(TICK_CYCLES - 1);
  wire oc_expired = oc_ms > oc_time;
  wire test_done = test_ms > sfp_pkg::TEST_HOLD_MS;
  // Millisecond timers saturate so a long condition cannot wrap back to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 32'h00000000;
      oc_ms <= 16'h0000;
      test_ms <= 16'h0000;
    end else if (ce) begin
      tick_cnt <= tick ? 32'h00000000 : tick_cnt + 32'h00000001;
      if (!s_cur) oc_ms <= 16'h0000;
      else if (tick && oc_ms != 16'hFFFF) oc_ms <= oc_ms + 16'h0001;
      if (!s_test) test_ms <= 16'h0000;
      else if (tick && test_ms != 16'hFFFF) test_ms <= test_ms + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Trip latches
  // ---------------------------------------------------------------
  // Setting wins over any clear so a live cause is never dropped
  wire clr_all = restart;
  wire clr_stop = restart | test_done;
  sfp_pkg::sfp_trip_t next_trip;
  assign next_trip.hard = hard_over | (trip.hard & ~clr_all);
  assign next_trip.overload = oc_expired | (trip.overload & ~clr_all);
  assign next_trip.thermal = (heatsink_temp >= temp_limit(ctrl.temp_sel)) | (trip.thermal & ~clr_all);
  assign next_trip.estop = s_estop | (trip.estop & ~clr_stop);
  wire any_next = |next_trip;
  wire soft_fault = soft_over & ~ctrl.soft_nofault;
  wire [7:0] next_msg = next_trip.estop ? sfp_pkg::MSG_STOP :
                        next_trip.hard ? sfp_pkg::MSG_HARD :
                        next_trip.overload ? sfp_pkg::MSG_OVERLOAD :
                        next_trip.thermal ? sfp_pkg::MSG_THERMAL : sfp_pkg::MSG_OK;
  wire [sfp_pkg::NUM_EVENTS-1:0] events = {soft_over & ~soft_q, next_trip & ~trip};

  // Protection outputs, all registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trip <= '0;
      soft_q <= 1'b0;
      msg <= sfp_pkg::MSG_OK;
      brake <= 1'b0;
      drive_enable <= 1'b0;
      pwm_limit <= 1'b0;
      fault <= 1'b0;
      error_indicator_a <= 1'b0;
      current_indicator_b <= 1'b0;
    end else if (ce) begin
      trip <= next_trip;
      soft_q <= soft_over;
      msg <= next_msg;
      brake <= any_next;
      drive_enable <= ~any_next;
      pwm_limit <= s_cur;
      fault <= any_next | soft_fault;
      error_indicator_a <= soft_over | next_trip.hard | next_trip.estop;
      current_indicator_b <= s_cur | next_trip.overload | next_trip.thermal | next_trip.estop;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_st <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      irq_st <= (irq_st & ~irq_clr) | events;
      irq <= |(((irq_st & ~irq_clr) | events) & irq_en);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_estop_brake;
    @(posedge clk) disable iff (!rst_n) (ce && s_estop) |=> (brake && !drive_enable && fault);
  endproperty
  a_estop_brake: assert property (p_estop_brake) else $error("Stop did not brake");
  property p_latch_hold;
    @(posedge clk) disable iff (!rst_n) (ce && trip.hard && !restart) |=> trip.hard;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("Trip cleared without restart");
  property p_hard_trip;
    @(posedge clk) disable iff (!rst_n) (ce && hard_over) |=> (trip.hard && brake);
  endproperty
  a_hard_trip: assert property (p_hard_trip) else $error("Hard limit missed");
  property p_err_track;
    @(posedge clk) disable iff (!rst_n) ce |=> (pos_err == $past(cmd_pos) - $past(actual_pos));
  endproperty
  a_err_track: assert property (p_err_track) else $error("Position error wrong");
  property p_oc_trip;
    @(posedge clk) disable iff (!rst_n) (ce && oc_expired) |=> trip.overload;
  endproperty
  a_oc_trip: assert property (p_oc_trip) else $error("Overload missed");
  property p_thermal;
    @(posedge clk) disable iff (!rst_n) (ce && heatsink_temp >= temp_limit(ctrl.temp_sel)) |=> !drive_enable;
  endproperty
  a_thermal: assert property (p_thermal) else $error("Thermal trip missed");
  property p_soft_nobrake;
    @(posedge clk) disable iff (!rst_n) (ce && soft_over && !any_next) |=> (error_indicator_a && !brake);
  endproperty
  a_soft_nobrake: assert property (p_soft_nobrake) else $error("Soft limit handling wrong");
  property p_cur_nofault;
    @(posedge clk) disable iff (!rst_n) (ce && s_cur && !any_next && !soft_fault) |=> (pwm_limit && !fault);
  endproperty
  a_cur_nofault: assert property (p_cur_nofault) else $error("Current limit faulted");
  property p_fault_latched;
    @(posedge clk) disable iff (!rst_n) (trip != '0) |-> (fault && brake);
  endproperty
  a_fault_latched: assert property (p_fault_latched) else $error("Fault dropped during trip");
  c_estop: cover property (@(posedge clk) disable iff (!rst_n) ce && s_estop ##1 brake);
  c_test_resume: cover property (@(posedge clk) disable iff (!rst_n) trip.estop ##1 !trip.estop);
  c_soft: cover property (@(posedge clk) disable iff (!rst_n) soft_q && !brake && fault);
endmodule // sfp_top
`default_nettype wire

// [tb/sfp_far_model.sv]
// Far-side model: quadrature encoder on the motor and the host watching fault.
// Assumes the block's clock; a move is loaded as a step count and direction.
`timescale 1ns/10ps
`default_nettype none
module sfp_far_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic up,
  input wire logic [7:0] steps,
  input wire logic [3:0] gap,
  input wire logic fault,
  output logic enc_a,
  output logic enc_b,
  output logic busy,
  output logic host_halt
);
  logic [1:0] ph;
  logic [7:0] left;
  logic [3:0] wait_cnt;
  // Gray walk, one edge per step, B leads A going up
  // Only the positive A and B lines are driven, no index line
  assign enc_a = ph[1];
  assign enc_b = ph[1] ^ ph[0];
  assign busy = (left != 8'h00);
  // Gap sets how slowly the shaft turns, so the sync path sees both rates
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 2'h0;
      left <= 8'h00;
      wait_cnt <= 4'h0;
    end else if (load) begin
      left <= steps;
      wait_cnt <= gap;
    end else if (busy && wait_cnt == 4'h0) begin
      ph <= up ? ph + 2'h1 : ph - 2'h1;
      left <= left - 8'h01;
      wait_cnt <= gap;
    end else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end
  end
  // Host halts its own motion while the fault line is up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_halt <= 1'b0;
    end else begin
      host_halt <= fault;
    end
  end
endmodule // sfp_far_model
`default_nettype wire

// [tb/tb_sfp_top.sv]
// Testbench for the servo fault supervisor: APB tasks and protection scenarios.
// Assumes a 10-cycle tick so that millisecond counts stay short.
`timescale 1ns/10ps
`default_nettype none
module tb_sfp_top;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, enc_a, enc_b;
  logic estop_n, test_button_n, current_high, brake, drive_enable, pwm_limit;
  logic fault, error_indicator_a, current_indicator_b, irq, load, up, busy, host_halt;
  logic [7:0] paddr, steps, heatsink_temp, thr;
  logic [31:0] pwdata, prdata, cmd_pos, rdv;
  logic [3:0] gap;
  int fail_count = 0;
  int num_checks = 0;
  int k;
  sfp_top #(.TICK_CYCLES(10), .POS_W(32)) sfp_top_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b),
    .estop_n(estop_n), .test_button_n(test_button_n), .current_high(current_high),
    .cmd_pos(cmd_pos), .heatsink_temp(heatsink_temp), .brake(brake),
    .drive_enable(drive_enable), .pwm_limit(pwm_limit), .fault(fault),
    .error_indicator_a(error_indicator_a), .current_indicator_b(current_indicator_b), .irq(irq));
  sfp_far_model sfp_far_model_inst (.clk(clk), .rst_n(rst_n), .load(load), .up(up),
    .steps(steps), .gap(gap), .fault(fault), .enc_a(enc_a), .enc_b(enc_b), .busy(busy),
    .host_halt(host_halt));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // A wait that used up its bound counts as a mismatch and ends the run
  task automatic limit(input int n, input int lim);
    if (n >= lim) begin
      fail_count++;
      $display("CHECK FAILED at %0t: wait timeout", $time);
      tally_and_finish();
    end
  endtask
  // One APB transfer; held until pready is seen, no latency assumed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    limit(n, 50);
    rdv = prdata;
    chk({31'h0, pslverr}, {31'h0, a > sfp_pkg::OFS_IRQ_ENABLE});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask
  // Packed as brake, drive_enable, fault, indicator A, indicator B, irq
  task automatic outs(input logic [5:0] e);
    chk({26'h0, brake, drive_enable, fault, error_indicator_a, current_indicator_b, irq}, {26'h0, e});
  endtask
  // Sign is the decoder's choice, so travel is judged by magnitude
  task automatic move(input logic u, input logic [7:0] n, input logic [31:0] e);
    up <= u;
    steps <= n;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (busy === 1'b1 && k < 500);
    limit(k, 500);
    cyc(6);
    apb(1'b0, sfp_pkg::OFS_POS_ERROR, 32'h0);
    chk(rdv[31] ? -rdv : rdv, e);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard: a run far past the plan counts as a mismatch
  initial begin
    cyc(60000);
    fail_count++;
    $display("CHECK FAILED at %0t: run timeout", $time);
    tally_and_finish();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, load, current_high} = 6'h00;
    {estop_n, test_button_n, up} = 3'h7;
    {paddr, steps, gap, pwdata, cmd_pos} = 84'h0;
    heatsink_temp = 8'h19;
    cyc(6);
    rst_n <= 1'b1;
    cyc(4);
    rchk(sfp_pkg::OFS_CTRL, 32'h1);
    rchk(sfp_pkg::OFS_HARD_LIMIT, 32'hBB8);
    rchk(sfp_pkg::OFS_IRQ_ENABLE, 32'h0);
    rchk(8'h24, 32'h0);
    rchk(sfp_pkg::OFS_POS_ERROR, 32'h0);
    outs(6'h10);
    // Encoder travel both ways, fast then slow, then A-edge mode
    move(1'b1, 8'h06, 32'h6);
    gap <= 4'h3;
    move(1'b0, 8'h06, 32'h0);
    wr(sfp_pkg::OFS_CTRL, 32'h0);
    move(1'b1, 8'h04, 32'h2);
    move(1'b0, 8'h04, 32'h0);
    wr(sfp_pkg::OFS_CTRL, 32'h1);
    // Soft overrun faults without brake, then suppressed
    wr(sfp_pkg::OFS_SOFT_LIMIT, 32'h3);
    wr(sfp_pkg::OFS_HARD_LIMIT, 32'h8);
    cmd_pos <= 32'h5;
    cyc(6);
    outs(6'h1C);
    wr(sfp_pkg::OFS_CTRL, 32'h3);
    cyc(4);
    outs(6'h14);
    wr(sfp_pkg::OFS_CTRL, 32'h1);
    cmd_pos <= 32'h0;
    cyc(6);
    outs(6'h10);
    wr(sfp_pkg::OFS_IRQ_CLEAR, 32'h1F);
    wr(sfp_pkg::OFS_IRQ_ENABLE, 32'h1F);
    // Hard trip latches; restart is refused while the cause lasts
    cmd_pos <= 32'h9;
    cyc(6);
    outs(6'h2D);
    chk({31'h0, host_halt}, 32'h1);
    apb(1'b0, sfp_pkg::OFS_STATUS, 32'h0);
    chk(rdv[15:0], {sfp_pkg::MSG_HARD, 8'h51});
    wr(sfp_pkg::OFS_CTRL, 32'h11);
    cmd_pos <= 32'h0;
    cyc(6);
    outs(6'h2D);
    rchk(sfp_pkg::OFS_IRQ_STATUS, 32'h11);
    wr(sfp_pkg::OFS_IRQ_CLEAR, 32'h1F);
    cyc(3);
    outs(6'h2C);
    wr(sfp_pkg::OFS_CTRL, 32'h11);
    cyc(6);
    outs(6'h10);
    // Current limiting: indicator only, then overload after the set time
    wr(sfp_pkg::OFS_IRQ_ENABLE, 32'h0);
    wr(sfp_pkg::OFS_OC_TIME, 32'h3);
    current_high <= 1'b1;
    cyc(6);
    outs(6'h12);
    chk({31'h0, pwm_limit}, 32'h1);
    cyc(60);
    outs(6'h2A);
    apb(1'b0, sfp_pkg::OFS_STATUS, 32'h0);
    chk(rdv[15:8], sfp_pkg::MSG_OVERLOAD);
    wr(sfp_pkg::OFS_IRQ_ENABLE, 32'h2);
    cyc(3);
    outs(6'h2B);
    current_high <= 1'b0;
    // Let the pin clear the sync stages first, else the live cause re-sets the trip
    cyc(4);
    wr(sfp_pkg::OFS_CTRL, 32'h11);
    wr(sfp_pkg::OFS_IRQ_CLEAR, 32'h1F);
    cyc(6);
    outs(6'h10);
    // Each thermal threshold: one below holds, the threshold trips; code 3 is the top one
    for (int i = 0; i < 4; i++) begin
      thr = (i == 0) ? sfp_pkg::TEMP_60 : (i == 1) ? sfp_pkg::TEMP_80 : sfp_pkg::TEMP_100;
      wr(sfp_pkg::OFS_CTRL, {28'h0, 2'(i), 2'b01});
      heatsink_temp <= thr - 8'h01;
      cyc(6);
      outs(6'h10);
      heatsink_temp <= thr;
      cyc(6);
      outs(6'h2A);
      apb(1'b0, sfp_pkg::OFS_STATUS, 32'h0);
      chk(rdv[15:8], sfp_pkg::MSG_THERMAL);
      heatsink_temp <= 8'h19;
      wr(sfp_pkg::OFS_CTRL, {28'h0000001, 2'(i), 2'b01});
      cyc(6);
      outs(6'h10);
    end
    // Emergency stop acts at once; a long test press resumes
    wr(sfp_pkg::OFS_CTRL, 32'h1);
    estop_n <= 1'b0;
    cyc(4);
    outs(6'h2E);
    apb(1'b0, sfp_pkg::OFS_STATUS, 32'h0);
    chk(rdv[15:8], sfp_pkg::MSG_STOP);
    estop_n <= 1'b1;
    test_button_n <= 1'b0;
    cyc(29000);
    outs(6'h2E);
    k = 0;
    while (drive_enable !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    limit(k, 3000);
    cyc(2);
    outs(6'h10);
    test_button_n <= 1'b1;
    // Reset in mid-run clears a latched trip and restores the limits
    cmd_pos <= 32'h9;
    cyc(6);
    outs(6'h2C);
    rst_n <= 1'b0;
    cyc(2);
    outs(6'h00);
    rst_n <= 1'b1;
    cyc(2);
    outs(6'h10);
    rchk(sfp_pkg::OFS_SOFT_LIMIT, 32'hA);
    rchk(sfp_pkg::OFS_POS_ERROR, 32'h9);
    tally_and_finish();
  end
endmodule // tb_sfp_top
`default_nettype wire
